// file: shared/breakpoint_request_pin_defs.svh
`ifndef BREAKPOINT_REQUEST_PIN_DEFS_SVH
`define BREAKPOINT_REQUEST_PIN_DEFS_SVH

// ----------------------------------------------------------------
// Bus cycle encodings
// ----------------------------------------------------------------
`define BK_FC_PROG 3'h6
`define BK_FC_CPU 3'h7
`define BK_SIZ_WORD 2'h2
`define BK_SIZ_LONG 2'h0

// ----------------------------------------------------------------
// Breakpoint acknowledge address layout
// ----------------------------------------------------------------
`define BK_CPU_TYPE_LSB 16
`define BK_CPU_TYPE0 4'h0
`define BK_LEVEL_LSB 2
`define BK_LEVEL_ALL 3'h7
`define BK_TBIT_POS 1
`define BK_WORD_STEP 32'h0000_0002

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BK_PIN_IDLE 5'h1f
`define BK_DATA_RST 32'h0000_0000

`endif

// file: shared/breakpoint_request_pin_pkg.sv
package breakpoint_request_pin_pkg;

  // Bus sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_ACK, ST_RETRY}
    state_type;

  // Whole state of the acknowledge unit
  typedef struct packed {
    state_type st;
    logic as;
    logic [31:0] addr;
    logic [2:0] fc;
    logic [1:0] siz;
    logic long_f;
    logic [1:0] pv;
    logic [15:0] w0;
    logic [15:0] w1;
    logic [31:0] a0;
    logic [31:0] a1;
    logic [1:0] brk;
    logic exc;
    logic cont;
    logic aerr;
    logic ferr;
    logic bdm;
  } unit_state_type;

endpackage

// file: design/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser for asynchronous pins
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins and synchronised copy
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] sync
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_state_type;

  sync_state_type q, d;

  // First stage feeds only the second
  always_comb
  begin
    d.s1 = pin;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= {RESET_VAL, RESET_VAL};
    end
    else
    begin
      q <= d;
    end
  end

  assign sync = q.s2;

endmodule // pin_sync

`default_nettype wire

// file: design/breakpoint_request_pin_ack_unit.sv
`timescale 1ns/10ps
`default_nettype none
`include "breakpoint_request_pin_defs.svh"

// Summary of operation
// - A breakpoint taken with background mode off runs a word read in CPU space type 0 with address bits 4..2 all ones and bit 1 set.
// - A bus error ending that read starts breakpoint exception processing.
// - A data-size acknowledge ending that read discards the data and lets execution continue without exception.
// - The breakpoint request pin is sampled alongside the fetched data and travels with it, so a flush before use loses it.
// - On a 32-bit fetch of two instructions an external request breaks after the first and before the second.
// - The internal address compare can flag either of the two fetched instructions on its own.
// - A prefetch from an odd address raises an address error and runs no bus cycle.
// - The bus error line is active low; with halt it asks for the cycle to be retried.
module breakpoint_request_pin_ack_unit
  import breakpoint_request_pin_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Core fetch request
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic bus32,
  output logic fetch_ready,
  input wire logic flush,
  // Instruction issue to core
  output logic instr_valid,
  input wire logic instr_ready,
  output logic [15:0] instr_word,
  output logic [31:0] instr_addr,
  // Internal breakpoint compare and mode
  input wire logic int_breakpoint_request_pin_en,
  input wire logic [31:0] int_breakpoint_request_pin_addr,
  input wire logic bdm_enable,
  // Events to core
  output logic breakpoint_request_pin_exception,
  output logic breakpoint_request_pin_continue,
  output logic address_error,
  output logic fetch_fault,
  output logic enter_background,
  // External bus
  output logic as_n,
  output logic [31:0] addr_out,
  output logic [2:0] fc_out,
  output logic [1:0] siz_out,
  input wire logic [31:0] data_in,
  input wire logic [1:0] data_size_ack_lines_n,
  input wire logic bus_error_line_i_n,
  output logic bus_error_line_o_n,
  output logic bus_error_line_oe,
  input wire logic halt_n,
  input wire logic breakpoint_request_pin_n
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [36:0] pins_s;
  logic [31:0] data_s;
  logic ack_s, bus_error_line_s, halt_s, breakpoint_request_pin_s;

  // Data and request share one path so they stay aligned
  pin_sync #(
    .WIDTH(37),
    .RESET_VAL({`BK_DATA_RST, `BK_PIN_IDLE})
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .pin({data_in, data_size_ack_lines_n, bus_error_line_i_n, halt_n,
          breakpoint_request_pin_n}),
    .sync(pins_s)
  );

  // Active-high views of the synchronised pins
  assign data_s = pins_s[36:5];
  assign ack_s = ~&pins_s[4:3];
  assign bus_error_line_s = ~pins_s[2];
  assign halt_s = ~pins_s[1];
  assign breakpoint_request_pin_s = ~pins_s[0];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  unit_state_type q, d;
  logic [31:0] next_addr, ack_addr;
  logic m0, m1;

  // Second slot address and internal matches per slot
  assign next_addr = q.addr + `BK_WORD_STEP;
  assign m0 = int_breakpoint_request_pin_en && (int_breakpoint_request_pin_addr[31:1] == q.addr[31:1]);
  assign m1 = int_breakpoint_request_pin_en && q.long_f
              && (int_breakpoint_request_pin_addr[31:1] == next_addr[31:1]);

  // Acknowledge address: type 0, all levels, T-bit set
  assign ack_addr = (32'(`BK_CPU_TYPE0) << `BK_CPU_TYPE_LSB)
                    | (32'(`BK_LEVEL_ALL) << `BK_LEVEL_LSB)
                    | (32'h0000_0001 << `BK_TBIT_POS);

  // Next state
  always_comb
  begin
    d = q;
    {d.exc, d.cont, d.aerr, d.ferr, d.bdm} = 5'h00;
    unique case (q.st)
      ST_IDLE:
      begin
        if (fetch_req && q.pv == 2'b00 && !flush)
        begin
          if (fetch_addr[0])
          begin
            d.aerr = 1'b1;
          end
          else
          begin
            d.st = ST_FETCH;
            d.as = 1'b1;
            d.addr = fetch_addr;
            d.fc = `BK_FC_PROG;
            d.long_f = bus32;
            d.siz = bus32 ? `BK_SIZ_LONG : `BK_SIZ_WORD;
          end
        end
        else if (q.pv[0] && instr_ready && !flush)
        begin
          // Retire slot 0; second slot moves up
          d.pv = {1'b0, q.pv[1]};
          d.w0 = q.w1;
          d.a0 = q.a1;
          d.brk = {1'b0, q.brk[1]};
          if (q.brk[0] && bdm_enable)
          begin
            d.bdm = 1'b1;
          end
          else if (q.brk[0])
          begin
            d.st = ST_ACK;
            d.as = 1'b1;
            d.addr = ack_addr;
            d.fc = `BK_FC_CPU;
            d.siz = `BK_SIZ_WORD;
          end
        end
      end
      ST_FETCH:
      begin
        if (bus_error_line_s && halt_s)
        begin
          d.st = ST_RETRY;
          d.as = 1'b0;
        end
        else if (bus_error_line_s)
        begin
          d.st = ST_IDLE;
          d.as = 1'b0;
          d.ferr = 1'b1;
        end
        else if (ack_s)
        begin
          // Request is latched with the same data sample
          d.st = ST_IDLE;
          d.as = 1'b0;
          d.pv = q.long_f ? 2'b11 : 2'b01;
          d.w0 = data_s[31:16];
          d.w1 = data_s[15:0];
          d.a0 = q.addr;
          d.a1 = next_addr;
          d.brk = {m1, breakpoint_request_pin_s | m0};
        end
      end
      ST_ACK:
      begin
        if (bus_error_line_s && halt_s)
        begin
          d.st = ST_RETRY;
          d.as = 1'b0;
        end
        else if (bus_error_line_s)
        begin
          d.st = ST_IDLE;
          d.as = 1'b0;
          d.exc = 1'b1;
        end
        else if (ack_s)
        begin
          // Returned data are never looked at
          d.st = ST_IDLE;
          d.as = 1'b0;
          d.cont = 1'b1;
        end
      end
      ST_RETRY:
      begin
        // Wait out the halt, then rerun the same cycle
        if (!halt_s && !bus_error_line_s)
        begin
          d.st = (q.fc == `BK_FC_CPU) ? ST_ACK : ST_FETCH;
          d.as = 1'b1;
        end
      end
    endcase
    // Flush drops anything not yet issued; a lone request dies here
    if (flush)
    begin
      d.pv = 2'b00;
      d.brk = 2'b00;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign fetch_ready = (q.st == ST_IDLE) && (q.pv == 2'b00);
  assign instr_valid = (q.st == ST_IDLE) && q.pv[0];
  assign instr_word = q.w0;
  assign instr_addr = q.a0;
  assign breakpoint_request_pin_exception = q.exc;
  assign breakpoint_request_pin_continue = q.cont;
  assign address_error = q.aerr;
  assign fetch_fault = q.ferr;
  assign enter_background = q.bdm;
  assign as_n = ~q.as;
  assign addr_out = q.addr;
  assign fc_out = q.fc;
  assign siz_out = q.siz;
  // This unit only listens on the bus error line
  assign bus_error_line_o_n = 1'b1;
  assign bus_error_line_oe = 1'b0;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ack_cycle_addr_a: assert property (
    q.st == ST_ACK |-> addr_out[4:1] == 4'hf && fc_out == `BK_FC_CPU
      && siz_out == `BK_SIZ_WORD && addr_out[19:16] == `BK_CPU_TYPE0
      && !as_n)
    else $error("acknowledge cycle address or space wrong");
  ack_start_a: assert property (
    q.st == ST_IDLE && instr_valid && instr_ready && q.brk[0]
      && !bdm_enable && !flush |=> q.st == ST_ACK ##0 !as_n)
    else $error("breakpoint not acknowledged");
  bus_error_line_exception_a: assert property (
    q.st == ST_ACK && bus_error_line_s && !halt_s
      |=> breakpoint_request_pin_exception && !breakpoint_request_pin_continue ##1 !breakpoint_request_pin_exception)
    else $error("bus error did not raise breakpoint exception");
  dsack_continue_a: assert property (
    q.st == ST_ACK && ack_s && !bus_error_line_s
      |=> breakpoint_request_pin_continue && !breakpoint_request_pin_exception && q.st == ST_IDLE)
    else $error("acknowledge did not continue");
  request_latch_a: assert property (
    q.st == ST_FETCH && ack_s && !bus_error_line_s && breakpoint_request_pin_s && !flush
      |=> q.brk[0] && q.pv[0])
    else $error("request not latched with data");
  split_break_a: assert property (
    q.st == ST_FETCH && q.long_f && ack_s && !bus_error_line_s && breakpoint_request_pin_s
      && !int_breakpoint_request_pin_en && !flush |=> q.brk == 2'b01 && q.pv == 2'b11)
    else $error("external break not placed after first word");
  second_match_a: assert property (
    q.st == ST_FETCH && ack_s && !bus_error_line_s && !flush && m1 && !m0
      && !breakpoint_request_pin_s |=> q.brk == 2'b10)
    else $error("internal match on second word lost");
  odd_fetch_a: assert property (
    fetch_ready && fetch_req && fetch_addr[0] && !flush
      |=> address_error && as_n && q.st == ST_IDLE)
    else $error("odd prefetch not trapped");
  retry_cycle_a: assert property (
    (q.st == ST_FETCH || q.st == ST_ACK) && bus_error_line_s && halt_s
      |=> as_n && q.st == ST_RETRY && !fetch_fault && !breakpoint_request_pin_exception)
    else $error("retry not honoured");
  ack_exc_c: cover property (q.st == ST_ACK ##1 breakpoint_request_pin_exception);
  ack_cont_c: cover property (q.st == ST_ACK ##1 breakpoint_request_pin_continue);
  long_break_c: cover property (q.pv == 2'b11 && q.brk == 2'b01);
  retry_c: cover property (q.st == ST_RETRY ##[1:20] q.st == ST_FETCH);

endmodule // breakpoint_request_pin_ack_unit

`default_nettype wire

// file: verif/bus_partner.sv
`timescale 1ns/10ps
`default_nettype none
`include "breakpoint_request_pin_defs.svh"

// ----------------------------------------------------------------
// External bus logic answering fetch and acknowledge cycles
// ----------------------------------------------------------------
module bus_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus from the unit
  input wire logic as_n,
  input wire logic [2:0] fc_out,
  input wire logic [31:0] addr_out,
  // Scenario controls
  input wire logic use_err,
  input wire logic use_halt,
  input wire logic arm,
  // Responses
  output logic [31:0] data_in,
  output logic [1:0] ack_n,
  output logic err_n,
  output logic halt_n,
  output logic req_pin_n
);
  logic resp_q;
  logic seen_q;
  logic [31:0] last_q;

  // Answer one cycle into the strobe, hold until one cycle after the strobe rises
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      resp_q <= 1'b0;
      seen_q <= 1'b0;
      last_q <= 32'h0000_0000;
    end
    else
    begin
      resp_q <= !as_n;
      if (!as_n && fc_out == `BK_FC_CPU)
        seen_q <= 1'b1;
      else if (!arm)
        seen_q <= 1'b0;
      if (resp_q)
        last_q <= data_in;
    end
  end

  // Idle data is inverted so a stale word never passes for a fresh one
  assign data_in = resp_q ?
    {addr_out[15:0] ^ 16'h5a5a, addr_out[15:0] ^ 16'h0ff0} : ~last_q;
  assign ack_n = (resp_q && !use_err) ? 2'h0 : 2'h3;
  assign err_n = !(resp_q && use_err);
  assign halt_n = !(resp_q && use_halt);
  // Request held until the acknowledge cycle shows on the bus
  assign req_pin_n = !(arm && !seen_q);
endmodule // bus_partner
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "breakpoint_request_pin_defs.svh"

module tb_top
  import breakpoint_request_pin_pkg::*;
;
  logic clk, rst, fetch_req, bus32, flush, instr_ready, int_breakpoint_request_pin_en;
  logic bdm_enable, fetch_ready, instr_valid, breakpoint_request_pin_exception, as_n;
  logic breakpoint_request_pin_continue, address_error, fetch_fault, enter_background;
  logic err_o_n, err_oe, err_n, err_line_n, halt_n, req_pin_n, prev_as;
  logic use_err, use_halt, arm;
  logic [31:0] fetch_addr, int_breakpoint_request_pin_addr, instr_addr, addr_out, data_in;
  logic [15:0] instr_word;
  logic [2:0] fc_out;
  logic [1:0] siz_out, ack_n;
  int failures, comparisons, cyc, n_exc, n_cont, n_aerr, n_ff, n_bg;
  int n_cyc, n_ack;

  // Open-drain wire: any party driving low wins
  assign err_line_n = err_n && (!err_oe || err_o_n);

  breakpoint_request_pin_ack_unit u_dut (.clk(clk), .rst(rst), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .bus32(bus32), .fetch_ready(fetch_ready),
    .flush(flush), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .instr_word(instr_word), .instr_addr(instr_addr),
    .int_breakpoint_request_pin_en(int_breakpoint_request_pin_en), .int_breakpoint_request_pin_addr(int_breakpoint_request_pin_addr),
    .bdm_enable(bdm_enable), .breakpoint_request_pin_exception(breakpoint_request_pin_exception),
    .breakpoint_request_pin_continue(breakpoint_request_pin_continue), .address_error(address_error),
    .fetch_fault(fetch_fault), .enter_background(enter_background),
    .as_n(as_n), .addr_out(addr_out), .fc_out(fc_out), .siz_out(siz_out),
    .data_in(data_in), .data_size_ack_lines_n(ack_n),
    .bus_error_line_i_n(err_line_n), .bus_error_line_o_n(err_o_n),
    .bus_error_line_oe(err_oe), .halt_n(halt_n),
    .breakpoint_request_pin_n(req_pin_n));

  bus_partner u_partner (.clk(clk), .rst(rst), .as_n(as_n),
    .fc_out(fc_out), .addr_out(addr_out), .use_err(use_err),
    .use_halt(use_halt), .arm(arm), .data_in(data_in), .ack_n(ack_n),
    .err_n(err_n), .halt_n(halt_n), .req_pin_n(req_pin_n));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Event counters and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc++;
    if (!rst)
    begin
      n_exc += (breakpoint_request_pin_exception === 1'b1);
      n_cont += (breakpoint_request_pin_continue === 1'b1);
      n_aerr += (address_error === 1'b1);
      n_ff += (fetch_fault === 1'b1);
      n_bg += (enter_background === 1'b1);
      n_cyc += (prev_as === 1'b1 && as_n === 1'b0);
      n_ack += (prev_as === 1'b1 && as_n === 1'b0 && fc_out == `BK_FC_CPU);
    end
    prev_as = as_n;
    if (cyc > 20000)
    begin
      failures++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic clr();
    {n_exc, n_cont, n_aerr, n_ff, n_bg, n_cyc, n_ack} = '0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic req(input logic [31:0] a, input logic b);
    @(negedge clk);
    fetch_req = 1'b1;
    fetch_addr = a;
    bus32 = b;
    @(negedge clk);
    fetch_req = 1'b0;
  endtask

  task automatic wait_as(input logic lvl);
    for (int i = 0; i < 60 && as_n !== lvl; i++) @(negedge clk);
    chk("as_n", 32'(as_n), 32'(lvl));
  endtask

  // Extra cycles let the released termination clear the synchroniser
  task automatic wait_valid();
    for (int i = 0; i < 60 && instr_valid !== 1'b1; i++) @(negedge clk);
    chk("instr_valid", 32'(instr_valid), 32'h1);
    idle(4);
  endtask

  task automatic fetch(input logic [31:0] a, input logic b);
    req(a, b);
    wait_as(1'b0);
    chk("addr_out", addr_out, a);
    chk("fc_out", 32'(fc_out), 32'(`BK_FC_PROG));
    chk("siz_out", 32'(siz_out), b ? 32'(`BK_SIZ_LONG) : 32'(`BK_SIZ_WORD));
    wait_valid();
    chk("instr_addr", instr_addr, a);
    chk("instr_word", 32'(instr_word), 32'(a[15:0] ^ 16'h5a5a));
  endtask

  task automatic retire();
    @(negedge clk);
    instr_ready = 1'b1;
    @(negedge clk);
    instr_ready = 1'b0;
  endtask

  task automatic bk_ack(input logic e);
    clr();
    use_err = e;
    retire();
    wait_as(1'b0);
    chk("ack addr", addr_out, 32'h0000_001e);
    chk("ack fc", 32'(fc_out), 32'(`BK_FC_CPU));
    chk("ack siz", 32'(siz_out), 32'(`BK_SIZ_WORD));
    wait_as(1'b1);
    idle(4);
    use_err = 1'b0;
    chk("ack cycles", 32'(n_ack), 32'h1);
    chk("exception", 32'(n_exc), 32'(e));
    chk("continue", 32'(n_cont), 32'(!e));
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rst, fetch_req, bus32, flush, instr_ready} = 5'h10;
    {int_breakpoint_request_pin_en, bdm_enable, use_err, use_halt, arm} = 5'h00;
    {fetch_addr, int_breakpoint_request_pin_addr} = '0;
    {failures, comparisons, cyc} = '0;
    prev_as = 1'b1;
    clr();
    repeat (12) @(negedge clk);
    rst = 1'b0;
    idle(2);
    chk("as_n idle", 32'(as_n), 32'h1);
    chk("fetch_ready", 32'(fetch_ready), 32'h1);
    chk("err_oe", 32'(err_oe), 32'h0);
    chk("err_o_n", 32'(err_o_n), 32'h1);
    // Long fetch pairs two words, no breakpoint
    clr();
    fetch(32'h0000_0200, 1'b1);
    retire();
    idle(2);
    chk("slot1 addr", instr_addr, 32'h0000_0202);
    chk("slot1 word", 32'(instr_word), 32'h0000_0df0);
    retire();
    idle(6);
    chk("no ack", 32'(n_ack), 32'h0);
    // Odd prefetch refused without a bus cycle
    clr();
    req(32'h0000_0301, 1'b0);
    idle(4);
    chk("addr error", 32'(n_aerr), 32'h1);
    chk("no cycle", 32'(n_cyc), 32'h0);
    // External request on a long fetch breaks between the two words
    arm = 1'b1;
    fetch(32'h0000_0400, 1'b1);
    bk_ack(1'b1);
    arm = 1'b0;
    chk("second word", instr_addr, 32'h0000_0402);
    clr();
    retire();
    idle(6);
    chk("one break", 32'(n_ack), 32'h0);
    // Acknowledge ended with data size lines resumes execution
    arm = 1'b1;
    fetch(32'h0000_0500, 1'b0);
    bk_ack(1'b0);
    arm = 1'b0;
    // Internal compare flags only the second word
    int_breakpoint_request_pin_en = 1'b1;
    int_breakpoint_request_pin_addr = 32'h0000_0602;
    fetch(32'h0000_0600, 1'b1);
    clr();
    retire();
    idle(6);
    chk("first clean", 32'(n_ack), 32'h0);
    bk_ack(1'b1);
    // Flush drops a latched request
    int_breakpoint_request_pin_en = 1'b0;
    arm = 1'b1;
    fetch(32'h0000_0700, 1'b0);
    arm = 1'b0;
    flush = 1'b1;
    @(negedge clk);
    flush = 1'b0;
    chk("flushed", 32'(instr_valid), 32'h0);
    clr();
    fetch(32'h0000_0700, 1'b0);
    retire();
    idle(6);
    chk("lost", 32'(n_ack), 32'h0);
    // Background mode replaces the acknowledge cycle
    {bdm_enable, int_breakpoint_request_pin_en} = 2'h3;
    int_breakpoint_request_pin_addr = 32'h0000_0800;
    fetch(32'h0000_0800, 1'b0);
    clr();
    retire();
    idle(6);
    chk("background", 32'(n_bg), 32'h1);
    chk("no bg ack", 32'(n_ack), 32'h0);
    {bdm_enable, int_breakpoint_request_pin_en} = 2'h0;
    // Bus error with halt retries the same address
    clr();
    {use_err, use_halt} = 2'h3;
    req(32'h0000_0900, 1'b0);
    wait_as(1'b0);
    wait_as(1'b1);
    idle(1);
    {use_err, use_halt} = 2'h0;
    wait_valid();
    chk("retry cycles", 32'(n_cyc), 32'h2);
    chk("retry addr", instr_addr, 32'h0000_0900);
    retire();
    idle(6);
    // Bus error with halt on the acknowledge reruns that cycle
    int_breakpoint_request_pin_en = 1'b1;
    int_breakpoint_request_pin_addr = 32'h0000_0b00;
    fetch(32'h0000_0b00, 1'b0);
    int_breakpoint_request_pin_en = 1'b0;
    clr();
    {use_err, use_halt} = 2'h3;
    retire();
    wait_as(1'b1);
    idle(1);
    {use_err, use_halt} = 2'h0;
    wait_as(1'b0);
    chk("rerun ack addr", addr_out, 32'h0000_001e);
    wait_as(1'b1);
    idle(4);
    chk("ack reruns", 32'(n_ack), 32'h2);
    chk("rerun continue", 32'(n_cont), 32'h1);
    chk("rerun no exc", 32'(n_exc), 32'h0);
    // Bus error alone faults the fetch
    clr();
    use_err = 1'b1;
    req(32'h0000_0a00, 1'b0);
    wait_as(1'b0);
    wait_as(1'b1);
    idle(1);
    use_err = 1'b0;
    idle(4);
    chk("fetch fault", 32'(n_ff), 32'h1);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
